// file: cpl_code_protect.sv
// Code protection decision logic for program memory, data EEPROM and configuration words.
`timescale 1ns/100ps
module cpl_code_protect (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Non-volatile protection settings
    input wire logic [cpl_pkg::NUM_BLOCKS-1:0] blockWriteLock,
    input wire logic [cpl_pkg::NUM_BLOCKS-1:0] blockTableReadLock,
    input wire logic eepromExternalGuard,
    input wire logic eepromWriteLock,
    input wire logic configWriteLockIn,
    // CPU table access
    input wire logic tableReq,
    input wire logic tableWriteOp,
    input wire logic [cpl_pkg::ADDR_W-1:0] tablePointer,
    input wire logic [cpl_pkg::ADDR_W-1:0] progCounter,
    input wire logic [7:0] tableWrData,
    input wire logic [7:0] memRdData,
    output logic tableGrant,
    output logic [7:0] tableRdData,
    // CPU data EEPROM access
    input wire logic eeReq,
    input wire logic eeWrite,
    output logic eeGrant,
    // External programmer access
    input wire logic progReq,
    input wire logic progWrite,
    input wire logic progEeprom,
    input wire logic [cpl_pkg::ADDR_W-1:0] progAddr,
    input wire logic [7:0] progWrData,
    input wire logic [1:0] progErase,
    input wire logic [cpl_pkg::NUM_BLOCKS-1:0] progEraseSel,
    output logic progGrant,
    // Configuration state
    output logic [7:0] progBlockProtectCfg,
    output logic [7:0] debugIsaCfg,
    output logic configWriteLock
);
    import cpl_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic cpl_region_t regionOf(input logic [ADDR_W-1:0] a);
        if (a <= BOOT_END) begin
            regionOf = CPL_REGION_BOOT;
        end else if (a <= USER_END) begin
            regionOf = CPL_REGION_USER;
        end else if (a >= CFG_BASE) begin
            regionOf = CPL_REGION_CFG;
        end else begin
            regionOf = CPL_REGION_OTHER;
        end
    endfunction

    // Boot area counts as block 0 here; it has no separate lock bits in this block.
    function automatic logic [1:0] blockOf(input logic [ADDR_W-1:0] a);
        blockOf = a[BLOCK_SHIFT+1:BLOCK_SHIFT];
    endfunction

    cpl_region_t tgtRegion;
    cpl_region_t pcRegion;
    logic [1:0] tgtBlock;
    logic [1:0] pcBlock;
    logic tgtIsUser;
    logic sameBlock;
    logic cfgTarget;
    logic idWordTarget;
    logic progTgtUser;
    logic [1:0] progBlock;

    always_comb begin
        tgtRegion = regionOf(tablePointer);
        pcRegion = regionOf(progCounter);
        tgtBlock = blockOf(tablePointer);
        pcBlock = blockOf(progCounter);
        tgtIsUser = (tgtRegion == CPL_REGION_USER) || (tgtRegion == CPL_REGION_BOOT);
        sameBlock = (pcRegion == tgtRegion) && (pcBlock == tgtBlock);
        cfgTarget = (tgtRegion == CPL_REGION_CFG) && (tablePointer < DEVID_LO);
        idWordTarget = (tablePointer >= DEVID_LO);
        progTgtUser = (regionOf(progAddr) == CPL_REGION_USER)
            || (regionOf(progAddr) == CPL_REGION_BOOT);
        progBlock = blockOf(progAddr);
    end

    // ------------------------------------------------------------
    // Configuration words
    // ------------------------------------------------------------
    logic [7:0] protCfg_ff;
    logic [7:0] nxt_protCfg;
    logic [7:0] dbgCfg_ff;
    logic [7:0] nxt_dbgCfg;
    logic cfgLock_ff;
    logic nxt_cfgLock;
    logic cfgLockSeen_ff;
    logic nxt_cfgLockSeen;
    logic cpuCfgWrite;
    logic progCfgWrite;
    logic [3:0] cpuCfgIdx;
    logic [3:0] progCfgIdx;
    logic [NUM_BLOCKS-1:0] eraseMask;

    always_comb begin
        cpuCfgIdx = tablePointer[3:0];
        progCfgIdx = progAddr[3:0];
        // CPU writes are refused while the configuration lock is set.
        cpuCfgWrite = tableReq && tableWriteOp && cfgTarget && !cfgLock_ff;
        progCfgWrite = progReq && progWrite && !progEeprom && (progAddr >= CFG_BASE)
            && (progAddr < DEVID_LO);
        nxt_protCfg = protCfg_ff;
        nxt_dbgCfg = dbgCfg_ff;
        nxt_cfgLock = cfgLock_ff;
        nxt_cfgLockSeen = 1'b1;
        // The lock is a strap caught once after reset release; later only the programmer moves it.
        if (!cfgLockSeen_ff) begin
            nxt_cfgLock = configWriteLockIn;
        end
        if (progCfgWrite && (progCfgIdx == CFG_IDX_PROT)) begin
            // Only the programmer may touch the lock; it uses bit 7 of the protect word.
            nxt_cfgLock = progWrData[7];
        end
        if (cpuCfgWrite && (cpuCfgIdx == CFG_IDX_PROT)) begin
            nxt_protCfg = protCfg_ff & (tableWrData | ~PROT_CFG_MASK);
        end else if (progCfgWrite && (progCfgIdx == CFG_IDX_PROT)) begin
            nxt_protCfg = protCfg_ff & (progWrData | ~PROT_CFG_MASK);
        end
        if (cpuCfgWrite && (cpuCfgIdx == CFG_IDX_DBG)) begin
            // Single-supply enable keeps its value: the CPU cannot change it.
            nxt_dbgCfg = (tableWrData & DBG_CFG_MASK & 8'hFB) | (dbgCfg_ff & 8'h04);
        end else if (progCfgWrite && (progCfgIdx == CFG_IDX_DBG)) begin
            nxt_dbgCfg = progWrData & DBG_CFG_MASK;
        end
        eraseMask = '0;
        case (cpl_erase_t'(progErase))
            CPL_ERASE_BLOCK: begin
                eraseMask = progEraseSel;
            end
            CPL_ERASE_CHIP: begin
                eraseMask = '1;
            end
            default: begin
                eraseMask = '0;
            end
        endcase
        // Erase only arrives on the programmer port, so the CPU can never re-open a guard.
        if (progReq) begin
            nxt_protCfg[GUARD_LSB +: NUM_BLOCKS] = nxt_protCfg[GUARD_LSB +: NUM_BLOCKS]
                | eraseMask;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            protCfg_ff <= PROT_CFG_RESET;
            dbgCfg_ff <= DBG_CFG_RESET;
            cfgLock_ff <= 1'b1;
            cfgLockSeen_ff <= 1'b0;
        end else begin
            protCfg_ff <= nxt_protCfg;
            dbgCfg_ff <= nxt_dbgCfg;
            cfgLock_ff <= nxt_cfgLock;
            cfgLockSeen_ff <= nxt_cfgLockSeen;
        end
    end

    // ------------------------------------------------------------
    // CPU table access decision
    // ------------------------------------------------------------
    logic [NUM_BLOCKS-1:0] blockReadGuard;
    logic tblAllow;
    logic readBlocked;
    logic [7:0] nxt_tableRdData;
    logic [7:0] tableRdData_ff;

    assign blockReadGuard = protCfg_ff[GUARD_LSB +: NUM_BLOCKS];

    always_comb begin
        readBlocked = tgtIsUser && !blockTableReadLock[tgtBlock] && !sameBlock;
        if (tableWriteOp) begin
            // Read guard bits are not consulted here.
            tblAllow = tgtIsUser ? blockWriteLock[tgtBlock] :
                (cfgTarget ? !cfgLock_ff : (tgtRegion == CPL_REGION_OTHER));
        end else begin
            tblAllow = !readBlocked;
        end
        nxt_tableRdData = tableRdData_ff;
        if (tableReq && !tableWriteOp) begin
            if (readBlocked) begin
                nxt_tableRdData = 8'h00;
            end else if (idWordTarget) begin
                nxt_tableRdData = tablePointer[0] ? DEVICE_ID[15:8] : DEVICE_ID[7:0];
            end else if (cfgTarget && (cpuCfgIdx == CFG_IDX_PROT)) begin
                nxt_tableRdData = protCfg_ff;
            end else if (cfgTarget && (cpuCfgIdx == CFG_IDX_DBG)) begin
                nxt_tableRdData = dbgCfg_ff;
            end else begin
                nxt_tableRdData = memRdData;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tableRdData_ff <= 8'h00;
        end else begin
            tableRdData_ff <= nxt_tableRdData;
        end
    end

    assign tableGrant = tableReq && tblAllow;
    assign tableRdData = tableRdData_ff;

    // ------------------------------------------------------------
    // Data EEPROM and programmer decisions
    // ------------------------------------------------------------
    assign eeGrant = eeReq && (!eeWrite || !eepromWriteLock);

    always_comb begin
        if (progEeprom) begin
            progGrant = progReq && !eepromExternalGuard
                && (!progWrite || !eepromWriteLock);
        end else if (progTgtUser) begin
            progGrant = progReq && blockReadGuard[progBlock];
        end else begin
            // ID and configuration space stay reachable even on a guarded part.
            progGrant = progReq;
        end
    end

    assign progBlockProtectCfg = protCfg_ff;
    assign debugIsaCfg = dbgCfg_ff;
    assign configWriteLock = cfgLock_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    guard_only_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (progErase == 2'b00 || !progReq) |=> ((protCfg_ff & ~$past(protCfg_ff)) == 8'h00))
        else $error("guard bit rose without an erase");
    locked_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tableReq && tableWriteOp && tgtIsUser && !blockWriteLock[tgtBlock]) |-> !tableGrant)
        else $error("table write granted to a locked block");
    foreign_read_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tableReq && !tableWriteOp && readBlocked) |=> (tableRdData == 8'h00))
        else $error("refused table read returned data");
    own_read_data_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tableReq && !tableWriteOp && tgtIsUser && sameBlock)
        |=> (tableRdData == $past(memRdData)))
        else $error("read from inside a locked block lost data");
    guard_blocks_prog_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (progReq && !progEeprom && progTgtUser && !blockReadGuard[progBlock]) |-> !progGrant)
        else $error("programmer reached a guarded block");
    ee_ext_guard_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (progEeprom && eepromExternalGuard) |-> !progGrant)
        else $error("programmer reached guarded eeprom");
    ee_write_lock_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eepromWriteLock && eeWrite) |-> !eeGrant)
        else $error("eeprom write passed the lock");
    ee_cpu_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eeReq && !eeWrite) |-> eeGrant)
        else $error("cpu eeprom read refused");
    cfg_lock_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfgLockSeen_ff && !progCfgWrite) |=> $stable(cfgLock_ff))
        else $error("config lock moved without programmer");
    write_open_grant_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tableReq && tableWriteOp && tgtIsUser && blockWriteLock[tgtBlock]) |-> tableGrant)
        else $error("open block refused a table write");
    id_word_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tableReq && !tableWriteOp && idWordTarget && tablePointer[0])
        |=> (tableRdData == DEVICE_ID[15:8]))
        else $error("device id high byte wrong");
    cfg_write_open_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tableReq && tableWriteOp && cfgTarget && !cfgLock_ff) |-> tableGrant)
        else $error("open config word refused a table write");
    guard_cpu_free_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tableReq && !tableWriteOp && tgtIsUser && blockTableReadLock[tgtBlock]) |-> tableGrant)
        else $error("read guard blocked a cpu table read");
    prog_open_block_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (progReq && !progEeprom && progTgtUser && blockReadGuard[progBlock]) |-> progGrant)
        else $error("programmer refused an open block");
    // Block erase is left to the bench; this pins the chip-wide case, which must open every guard.
    erase_reopens_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (progReq && (progErase == CPL_ERASE_CHIP)) |=> (&blockReadGuard))
        else $error("chip erase left a guard set");
    ee_prog_open_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (progReq && progEeprom && !progWrite && !eepromExternalGuard) |-> progGrant)
        else $error("programmer refused open eeprom read");
    ee_prog_wr_lock_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (progEeprom && progWrite && eepromWriteLock) |-> !progGrant)
        else $error("programmer eeprom write passed the lock");
    // Programmer traffic is left out, since an erase may move the guards in the same cycle.
    cfg_locked_kept_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tableReq && tableWriteOp && cfgTarget && cfgLock_ff && !progReq)
        |=> ($stable(protCfg_ff) && $stable(dbgCfg_ff)))
        else $error("cpu changed a locked config word");
    // Catching the strap once keeps the lock valid without a load sequence after reset.
    lock_strap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!cfgLockSeen_ff && !progCfgWrite) |=> (cfgLock_ff == $past(configWriteLockIn)))
        else $error("config lock strap not captured");
    foreign_block_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tableReq && !tableWriteOp && tgtIsUser && !blockTableReadLock[tgtBlock]
        && (progCounter[BLOCK_SHIFT+1:BLOCK_SHIFT] != tablePointer[BLOCK_SHIFT+1:BLOCK_SHIFT]))
        |-> !tableGrant)
        else $error("table read crossed a locked block");
endmodule

// file: cpl_pkg.sv
// Constants and types for the code protection logic.
// Behaviour
// - CPU table reads and writes reach any program address, subject to block protection.
// - Table reads return the device ID; table reads and writes reach the config words.
// - Read guard bits never change CPU accesses; they only block the external programmer.
// - A cleared read guard bit refuses programmer reads and writes of that block.
// - A block whose write lock bit is 0 ignores every table write aimed at it.
// - A table read from code inside a table-read-locked block, in the same boot or user region as the target, still returns stored data.
// - A table read from code outside a table-read-locked block is refused and returns zero.
// - Read guard bits accept only 1-to-0 writes; writing a 1 over a 0 does nothing.
// - Guard bits return to 1 only at reset or by chip or block erase, started from the programmer port.
// - An active EEPROM external guard blocks programmer reads and writes of all EEPROM.
// - An active EEPROM write lock blocks CPU and programmer writes to all data EEPROM.
// - The CPU may always read data EEPROM, whatever the EEPROM protection bits hold.
// - After the reset strap is caught, only the programmer changes the config write lock, which guards the config words from CPU writes.
// - Block read guards sit in bits 0 to 3 of a config word; 1 is unprotected, erased is 1.
package cpl_pkg;
    localparam int ADDR_W = 22;
    localparam int NUM_BLOCKS = 4;
    localparam int BLOCK_SHIFT = 13;
    localparam logic [ADDR_W-1:0] BOOT_END = 22'h0007FF;
    localparam logic [ADDR_W-1:0] USER_END = 22'h007FFF;
    localparam logic [ADDR_W-1:0] ID_BASE = 22'h200000;
    localparam logic [ADDR_W-1:0] CFG_BASE = 22'h300000;
    localparam logic [ADDR_W-1:0] DEVID_LO = 22'h3FFFFE;
    localparam logic [3:0] CFG_IDX_DBG = 4'h6;
    localparam logic [3:0] CFG_IDX_PROT = 4'h8;
    localparam logic [7:0] DBG_CFG_RESET = 8'h85;
    localparam logic [7:0] DBG_CFG_MASK = 8'hC5;
    localparam logic [7:0] PROT_CFG_RESET = 8'h0F;
    localparam logic [7:0] PROT_CFG_MASK = 8'h0F;
    localparam int GUARD_LSB = 0;
    localparam logic [15:0] DEVICE_ID = 16'h5A01; // Arbitrary value.
    typedef enum logic [1:0] {
        CPL_REGION_USER = 2'b00,
        CPL_REGION_BOOT = 2'b01,
        CPL_REGION_CFG = 2'b10,
        CPL_REGION_OTHER = 2'b11
    } cpl_region_t;
    typedef enum logic [1:0] {
        CPL_ERASE_NONE = 2'b00,
        CPL_ERASE_BLOCK = 2'b01,
        CPL_ERASE_CHIP = 2'b10
    } cpl_erase_t;
endpackage

// file: cpl_mem_model.sv
// Program memory model that answers the protection block's raw read port.
`timescale 1ns/100ps
module cpl_mem_model (
    // Address from the table pointer
    input wire logic [cpl_pkg::ADDR_W-1:0] tablePointer,
    // Raw byte at that address
    output logic [7:0] memRdData
);
    import cpl_pkg::*;
    // The image is a fixed pattern and writes are not stored.
    // This keeps expected read data a pure function of the address.
    // A bench must therefore never read back a location that it wrote.
    assign memRdData = tablePointer[7:0] ^ 8'h3C;
endmodule

// file: code_protection_logic_bench.sv
// Self-checking bench for the code protection logic.
`timescale 1ns/100ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected %0t %s", $time, m); end end
module code_protection_logic_bench;
    import cpl_pkg::*;
    logic core_clk, reset_n, eepromExternalGuard, eepromWriteLock, configWriteLockIn;
    logic [3:0] blockWriteLock, blockTableReadLock, progEraseSel;
    logic tableReq, tableWriteOp, tableGrant, eeReq, eeWrite, eeGrant, configWriteLock;
    logic progReq, progWrite, progEeprom, progGrant;
    logic [21:0] tablePointer, progCounter, progAddr;
    logic [7:0] tableWrData, memRdData, tableRdData, progWrData, progBlockProtectCfg, debugIsaCfg;
    logic [1:0] progErase, kb;
    int n_mismatch, checked;
    typedef struct {
        logic wr; logic [21:0] ptr; logic [21:0] pc;
        logic [3:0] rdL; logic [3:0] wrL; logic g; logic [7:0] d;
    } cpl_row_t;
    cpl_row_t rows [10] = '{
        '{1'h0, 22'h002010, 22'h002000, 4'hD, 4'hF, 1'h1, 8'h2C},
        '{1'h0, 22'h002010, 22'h004000, 4'hD, 4'hF, 1'h0, 8'h00},
        '{1'h0, 22'h000100, 22'h000700, 4'hE, 4'hF, 1'h1, 8'h3C},
        '{1'h0, 22'h000100, 22'h006000, 4'hE, 4'hF, 1'h0, 8'h00},
        '{1'h0, 22'h007FFF, 22'h006000, 4'h7, 4'hF, 1'h1, 8'hC3},
        '{1'h1, 22'h004000, 22'h000000, 4'hF, 4'hB, 1'h0, 8'h00},
        '{1'h1, 22'h004000, 22'h000000, 4'hF, 4'hF, 1'h1, 8'h00},
        '{1'h1, 22'h001FFF, 22'h002000, 4'hF, 4'hE, 1'h0, 8'h00},
        '{1'h0, 22'h3FFFFE, 22'h000000, 4'h0, 4'hF, 1'h1, 8'h01},
        '{1'h0, 22'h3FFFFF, 22'h000000, 4'h0, 4'hF, 1'h1, 8'h5A}};

    cpl_code_protect dut (.core_clk(core_clk), .reset_n(reset_n),
        .blockWriteLock(blockWriteLock), .blockTableReadLock(blockTableReadLock),
        .eepromExternalGuard(eepromExternalGuard), .eepromWriteLock(eepromWriteLock),
        .configWriteLockIn(configWriteLockIn), .tableReq(tableReq),
        .tableWriteOp(tableWriteOp), .tablePointer(tablePointer), .progCounter(progCounter),
        .tableWrData(tableWrData), .memRdData(memRdData), .tableGrant(tableGrant),
        .tableRdData(tableRdData), .eeReq(eeReq), .eeWrite(eeWrite), .eeGrant(eeGrant),
        .progReq(progReq), .progWrite(progWrite), .progEeprom(progEeprom),
        .progAddr(progAddr), .progWrData(progWrData), .progErase(progErase),
        .progEraseSel(progEraseSel), .progGrant(progGrant),
        .progBlockProtectCfg(progBlockProtectCfg), .debugIsaCfg(debugIsaCfg),
        .configWriteLock(configWriteLock));
    cpl_mem_model mem (.tablePointer(tablePointer), .memRdData(memRdData));

    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    // Bit 1 of g skips the grant check where the grant is left open.
    task automatic tbl(input logic wr, input logic [21:0] ptr, input logic [21:0] pc,
            input logic [7:0] d, input logic [1:0] g, input logic [7:0] rd);
        @(negedge core_clk);
        progReq = 1'h0;
        tableReq = 1'h1;
        tableWriteOp = wr;
        tablePointer = ptr;
        progCounter = pc;
        tableWrData = d;
        #1;
        if (!g[1]) `CHK(tableGrant, g[0], "table grant")
        @(posedge core_clk);
        #1;
        if (!wr) `CHK(tableRdData, rd, "table read data")
    endtask

    task automatic prog(input logic wr, input logic ee, input logic [21:0] a,
            input logic [7:0] d, input logic [1:0] er, input logic [3:0] sel,
            input logic [1:0] g);
        @(negedge core_clk);
        tableReq = 1'h0;
        progReq = 1'h1;
        progWrite = wr;
        progEeprom = ee;
        progAddr = a;
        progWrData = d;
        progErase = er;
        progEraseSel = sel;
        #1;
        if (!g[1]) `CHK(progGrant, g[0], "programmer grant")
        @(posedge core_clk);
        #1;
    endtask

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {tableReq, tableWriteOp, eeReq, eeWrite, progReq, progWrite, progEeprom} = 7'h00;
        {eepromExternalGuard, eepromWriteLock, configWriteLockIn} = 3'h0;
        {tablePointer, progCounter, progAddr} = 66'h0;
        {tableWrData, progWrData, progErase, progEraseSel} = 22'h0;
        blockWriteLock = 4'hF;
        blockTableReadLock = 4'hF;
        n_mismatch = 0;
        checked = 0;
        reset_n = 1'h0;
        repeat (8) @(posedge core_clk);
        #1;
        `CHK(progBlockProtectCfg, 8'h0F, "protect word reset")
        `CHK(debugIsaCfg, 8'h85, "debug word reset")
        `CHK(configWriteLock, 1'h1, "lock reset")
        `CHK(tableRdData, 8'h00, "read data reset")
        @(negedge core_clk) reset_n = 1'h1;
        @(posedge core_clk);
        #1;
        `CHK(configWriteLock, 1'h0, "lock strap")
        for (int i = 0; i < 10; i++) begin
            blockTableReadLock = rows[i].rdL;
            blockWriteLock = rows[i].wrL;
            tbl(rows[i].wr, rows[i].ptr, rows[i].pc, 8'h00, {1'h0, rows[i].g},
                rows[i].d);
        end
        blockTableReadLock = 4'hF;
        blockWriteLock = 4'hF;
        prog(1'h0, 1'h0, 22'h002000, 8'h00, CPL_ERASE_NONE, 4'h0, 2'h1);
        tbl(1'h0, CFG_BASE + 22'h000008, 22'h0, 8'h00, 2'h1, 8'h0F);
        tbl(1'h1, CFG_BASE + 22'h000008, 22'h0, 8'h0D, 2'h1, 8'h00);
        `CHK(progBlockProtectCfg, 8'h0D, "guard clear")
        prog(1'h0, 1'h0, 22'h002000, 8'h00, CPL_ERASE_NONE, 4'h0, 2'h0);
        prog(1'h1, 1'h0, 22'h003FFF, 8'h00, CPL_ERASE_NONE, 4'h0, 2'h0);
        prog(1'h0, 1'h0, 22'h000000, 8'h00, CPL_ERASE_NONE, 4'h0, 2'h1);
        tbl(1'h0, 22'h002010, 22'h000000, 8'h00, 2'h1, 8'h2C);
        tbl(1'h1, CFG_BASE + 22'h000008, 22'h0, 8'h0F, 2'h2, 8'h00);
        `CHK(progBlockProtectCfg, 8'h0D, "guard set refused")
        prog(1'h0, 1'h0, 22'h0, 8'h00, CPL_ERASE_BLOCK, 4'h2, 2'h2);
        `CHK(progBlockProtectCfg, 8'h0F, "block erase")
        tbl(1'h1, CFG_BASE + 22'h000008, 22'h0, 8'h00, 2'h1, 8'h00);
        `CHK(progBlockProtectCfg, 8'h00, "guard clear all")
        prog(1'h0, 1'h0, 22'h0, 8'h00, CPL_ERASE_CHIP, 4'h0, 2'h2);
        `CHK(progBlockProtectCfg, 8'h0F, "chip erase")
        for (int k = 0; k < 4; k++) begin
            kb = k[1:0];
            @(negedge core_clk);
            progReq = 1'h0;
            eepromExternalGuard = kb[0];
            eepromWriteLock = kb[1];
            eeReq = 1'h1;
            eeWrite = 1'h0;
            #1 `CHK(eeGrant, 1'h1, "eeprom cpu read")
            @(negedge core_clk) eeWrite = 1'h1;
            #1 `CHK(eeGrant, ~kb[1], "eeprom cpu write")
            @(negedge core_clk) eeReq = 1'h0;
            prog(1'h0, 1'h1, 22'h0, 8'h00, CPL_ERASE_NONE, 4'h0, {1'h0, ~kb[0]});
            prog(1'h1, 1'h1, 22'h0, 8'h00, CPL_ERASE_NONE, 4'h0, {1'h0, ~|kb});
        end
        tbl(1'h1, CFG_BASE + 22'h000006, 22'h0, 8'h00, 2'h1, 8'h00);
        `CHK(debugIsaCfg, 8'h04, "cpu config write")
        tbl(1'h0, CFG_BASE + 22'h000006, 22'h0, 8'h00, 2'h1, 8'h04);
        prog(1'h1, 1'h0, CFG_BASE + 22'h000006, 8'hFF, CPL_ERASE_NONE, 4'h0, 2'h1);
        `CHK(debugIsaCfg, 8'hC5, "programmer config write")
        prog(1'h1, 1'h0, CFG_BASE + 22'h000008, 8'h8F, CPL_ERASE_NONE, 4'h0, 2'h1);
        `CHK(configWriteLock, 1'h1, "lock by programmer")
        tbl(1'h1, CFG_BASE + 22'h000008, 22'h0, 8'h00, 2'h0, 8'h00);
        `CHK(progBlockProtectCfg, 8'h0F, "locked word kept")
        @(negedge core_clk);
        tableReq = 1'h0;
        progReq = 1'h0;
        report_and_stop();
    end
endmodule
